// ==== pcs_consts.svh ====
// Offsets, codes and fixed values of the capability settings bank
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_AW 8
`define PCS_OFF_DEV_CAP 8'h00
`define PCS_OFF_DEV_CTRL 8'h04
`define PCS_OFF_DEV_CAP2 8'h08
`define PCS_OFF_CREDIT 8'h0c
`define PCS_OFF_LINK_CAP 8'h10
`define PCS_OFF_LINK_CTRL2 8'h14
`define PCS_OFF_LINK_STAT 8'h18
`define PCS_OFF_INTX 8'h1c
`define PCS_OFF_MSI 8'h20
`define PCS_OFF_MSIX_CTRL 8'h24
`define PCS_OFF_MSIX_TBL 8'h28
`define PCS_OFF_MSIX_PBA 8'h2c
`define PCS_OFF_PM_CAP 8'h30
`define PCS_OFF_PM_CTRL 8'h34
`define PCS_OFF_PM_DATA 8'h38
`define PCS_OFF_OPTS 8'h3c
`define PCS_RESP_OKAY 2'h0
`define PCS_RESP_SLVERR 2'h2
`define PCS_SPEED_5G 4'h2
`define PCS_DEEMPH_FIXED 1'h1
`define PCS_DEEMPH_OFF 1'h0
`define PCS_PIN_INTA 8'h01
`define PCS_PIN_NONE 8'h00
`define PCS_PM_POWER_ZERO 32'h0000_0000
`define PCS_CRED_PH_STD 8'h20
`define PCS_CRED_PH_BM 8'h40
`define PCS_CRED_NPH_STD 8'h10
`define PCS_CRED_NPH_BM 8'h08
`define PCS_CRED_INFINITE 8'h00
`endif

// ==== pcs_pkg.sv ====
// Types of the capability settings bank
package pcs_pkg;
    typedef enum logic [1:0] {PCS_D0, PCS_D1, PCS_D2, PCS_D3HOT} pcs_pm_t;

    // Build-time option set, one field per documented choice
    typedef struct packed {
        logic [2:0] mps;
        logic [1:0] phantom;
        logic ext_tag;
        logic ext_tag_dflt;
        logic ur_atomic;
        logic at32;
        logic at64;
        logic cas128;
        logic finite_cpl;
        logic [7:0] cpl_space;
        logic bus_master_opt;
        logic [3:0] sup_speed;
        logic [5:0] max_width;
        logic [1:0] aspm_sup;
        logic aspm_opt;
        logic dll_rpt;
        logic [3:0] tgt_speed;
        logic hw_auto_dis;
        logic slot_clk;
        logic intx_en;
        logic intx_pin_a;
        logic msi_en;
        logic msi64;
        logic [2:0] msi_mmc;
        logic msi_pvm;
        logic msix_en;
        logic [10:0] msix_size;
        logic [2:0] msix_bir;
        logic [28:0] msix_off;
        logic [2:0] pba_bir;
        logic [28:0] pba_off;
        logic [5:0] mem_bar_mask;
        logic [5:0] bar64_mask;
        logic dsi;
        logic d1;
        logic d2;
        logic [4:0] pme_from;
    } pcs_cfg_t;

    localparam pcs_cfg_t PCS_CFG_DFLT = '{sup_speed: 4'h1, tgt_speed: 4'h1,
        max_width: 6'h01, default: '0};

    // Register word layouts
    typedef struct packed {
        logic [25:0] rsvd; logic ext_tag; logic [1:0] phantom; logic [2:0] mps;
    } pcs_dev_cap_t;
    typedef struct packed {
        logic [21:0] rsvd; logic cas128; logic at64; logic at32; logic [6:0] rsvd0;
    } pcs_dev_cap2_t;
    typedef struct packed {
        logic [7:0] rsvd; logic [7:0] cpl_hdr; logic [7:0] np_hdr; logic [7:0] p_hdr;
    } pcs_credit_t;
    typedef struct packed {
        logic [10:0] rsvd; logic dll_rpt; logic [7:0] rsvd0; logic [1:0] aspm;
        logic [5:0] width; logic [3:0] speed;
    } pcs_link_cap_t;
    typedef struct packed {
        logic [24:0] rsvd; logic deemph; logic hw_auto_dis; logic [0:0] rsvd0;
        logic [3:0] tgt_speed;
    } pcs_link_ctrl2_t;
    typedef struct packed {
        logic [25:0] rsvd; logic pvm; logic [2:0] mmc; logic is64; logic present;
    } pcs_msi_t;
    typedef struct packed {
        logic [19:0] rsvd; logic enable; logic [10:0] size;
    } pcs_msix_ctrl_t;
    typedef struct packed {
        logic [28:0] offset; logic [2:0] bir;
    } pcs_msix_loc_t;
    typedef struct packed {
        logic [15:0] rsvd; logic [4:0] pme_from; logic d2; logic d1; logic [2:0] rsvd1;
        logic dsi; logic [4:0] rsvd0;
    } pcs_pm_cap_t;
    typedef struct packed {
        logic [27:0] rsvd; logic no_soft_reset; logic [0:0] rsvd0; pcs_pm_t state;
    } pcs_pm_ctrl_t;
endpackage

// ==== pcs_bank.sv ====
// Capability settings bank with AXI4-Lite register access and event gating
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"

// Behaviour
// - Tag width 8 bits if extended, else 5
// - Extended-tag default sets control bit 8
// - Phantom field gives function bits added
// - Atomic reject answers UR, else forwards
// - Separate 32/64-bit atomic, 128-bit CAS bits
// - Finite completions advertise real space
// - Bus-master option selects tuned credits
// - ASPM optionality reports ASPM disabled
// - Configurable data-link-active reporting bit
// - Target speed caps speed; editable at 5G
// - Autonomous disable: only reliability downshifts
// - Fixed de-emphasis when running 5.0 Gb/s
// - Slot clock bit follows reference clock choice
// - Legacy interrupts only when enabled
// - Only INTA; pin none means no interrupts
// - MSI: 64-bit, vector count, masking options
// - MSI-X needs memory BAR; BIR plus offset
// - BIR names lower dword of 64-bit BAR
// - Wake requests honoured only in advertised states
// - D3hot to D0 keeps configuration context
// - Power budget reads zero watts; no power budget word is mapped here
// - Power dissipation reads zero watts
module pcs_bank
    import pcs_pkg::*;
#(
    parameter pcs_cfg_t CFG = PCS_CFG_DFLT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`PCS_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`PCS_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic atomic_req,
    output logic atomic_ur,
    output logic atomic_fwd,
    input wire logic intx_req,
    output logic intx_send,
    input wire logic power_wake_request,
    output logic pme_send,
    input wire logic speed_req,
    input wire logic [3:0] speed_req_to,
    input wire logic speed_req_reliab,
    input wire logic [3:0] link_speed_now,
    output logic speed_grant,
    output logic speed_deny,
    output logic [3:0] link_target_speed,
    output logic deemph_level,
    output logic ext_tag_active,
    output logic [1:0] phantom_bits,
    output logic msix_active
);
    // A BIR pointing at the upper half of a 64-bit pair is moved to its lower half
    function automatic logic [2:0] lower_bir(input logic [2:0] bir);
        lower_bir = bir;
        if (bir[0] && bir != 3'h7 && CFG.bar64_mask[bir - 3'h1]) begin
            lower_bir = bir - 3'h1;
        end
    endfunction

    // Fixed capability words, derived once from the build options
    pcs_dev_cap_t w_dev_cap;
    pcs_dev_cap2_t w_dev_cap2;
    pcs_credit_t w_credit;
    pcs_link_cap_t w_link_cap;
    pcs_link_ctrl2_t w_link_ctrl2;
    pcs_msi_t w_msi;
    pcs_msix_ctrl_t w_msix_ctrl;
    pcs_msix_loc_t w_msix_tbl;
    pcs_msix_loc_t w_msix_pba;
    pcs_pm_cap_t w_pm_cap;
    logic [31:0] w_link_stat;
    logic [31:0] w_intx;
    logic [31:0] w_opts;
    logic [3:0] eff_tgt_speed;
    logic msix_ok;
    logic intx_ok;

    // Target is only free to differ from supported speed in a 5G build
    assign eff_tgt_speed = (CFG.sup_speed == `PCS_SPEED_5G) ? CFG.tgt_speed
                                                            : CFG.sup_speed;
    assign msix_ok = CFG.msix_en && (|CFG.mem_bar_mask);
    assign intx_ok = CFG.intx_en && CFG.intx_pin_a;

    // Capability word assembly
    assign w_dev_cap = '{rsvd: '0, ext_tag: CFG.ext_tag,
                         phantom: CFG.phantom, mps: CFG.mps};
    assign w_dev_cap2 = '{rsvd: '0, cas128: CFG.cas128, at64: CFG.at64,
                          at32: CFG.at32, rsvd0: '0};
    assign w_credit = '{rsvd: '0,
        cpl_hdr: CFG.finite_cpl ? CFG.cpl_space : `PCS_CRED_INFINITE,
        np_hdr: CFG.bus_master_opt ? `PCS_CRED_NPH_BM : `PCS_CRED_NPH_STD,
        p_hdr: CFG.bus_master_opt ? `PCS_CRED_PH_BM : `PCS_CRED_PH_STD};
    assign w_link_cap = '{rsvd: '0, dll_rpt: CFG.dll_rpt, rsvd0: '0,
                          aspm: CFG.aspm_opt ? 2'h0 : CFG.aspm_sup,
                          width: CFG.max_width, speed: CFG.sup_speed};
    assign w_link_ctrl2 = '{rsvd: '0, deemph: `PCS_DEEMPH_FIXED, hw_auto_dis: CFG.hw_auto_dis,
                            rsvd0: '0, tgt_speed: eff_tgt_speed};
    assign w_link_stat = {19'h0, CFG.slot_clk, 12'h000};
    assign w_intx = {23'h0, intx_ok, intx_ok ? `PCS_PIN_INTA : `PCS_PIN_NONE};
    assign w_msi = '{rsvd: '0, pvm: CFG.msi_pvm, mmc: CFG.msi_mmc,
                     is64: CFG.msi64, present: CFG.msi_en};
    assign w_msix_ctrl = '{rsvd: '0, enable: msix_ok, size: CFG.msix_size};
    assign w_msix_tbl = '{offset: CFG.msix_off, bir: lower_bir(CFG.msix_bir)};
    assign w_msix_pba = '{offset: CFG.pba_off, bir: lower_bir(CFG.pba_bir)};
    assign w_pm_cap = '{rsvd: '0, pme_from: CFG.pme_from,
                        d2: CFG.d2, d1: CFG.d1, rsvd1: '0, dsi: CFG.dsi, rsvd0: '0};
    assign w_opts = {28'h0, CFG.ur_atomic, CFG.bus_master_opt, CFG.finite_cpl, CFG.ext_tag_dflt};

    // Bus and writable register state
    logic aw_held, next_aw_held;
    logic [`PCS_AW-1:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [15:0] dev_ctrl, next_dev_ctrl;
    pcs_pm_t pm_state, next_pm_state;

    // Word read at an address; hit reports a mapped location
    function automatic logic [32:0] read_word(input logic [`PCS_AW-1:0] a);
        unique case (a)
            `PCS_OFF_DEV_CAP: read_word = {1'b1, w_dev_cap};
            `PCS_OFF_DEV_CTRL: read_word = {1'b1, 16'h0, dev_ctrl};
            `PCS_OFF_DEV_CAP2: read_word = {1'b1, w_dev_cap2};
            `PCS_OFF_CREDIT: read_word = {1'b1, w_credit};
            `PCS_OFF_LINK_CAP: read_word = {1'b1, w_link_cap};
            `PCS_OFF_LINK_CTRL2: read_word = {1'b1, w_link_ctrl2};
            `PCS_OFF_LINK_STAT: read_word = {1'b1, w_link_stat};
            `PCS_OFF_INTX: read_word = {1'b1, w_intx};
            `PCS_OFF_MSI: read_word = {1'b1, w_msi};
            `PCS_OFF_MSIX_CTRL: read_word = {1'b1, w_msix_ctrl};
            `PCS_OFF_MSIX_TBL: read_word = {1'b1, w_msix_tbl};
            `PCS_OFF_MSIX_PBA: read_word = {1'b1, w_msix_pba};
            `PCS_OFF_PM_CAP: read_word = {1'b1, w_pm_cap};
            `PCS_OFF_PM_CTRL: read_word = {1'b1, pcs_pm_ctrl_t'{rsvd: '0,
                no_soft_reset: 1'b1, rsvd0: '0, state: pm_state}};
            `PCS_OFF_PM_DATA: read_word = {1'b1, `PCS_PM_POWER_ZERO};
            `PCS_OFF_OPTS: read_word = {1'b1, w_opts};
            default: read_word = {1'b0, 32'h0};
        endcase
    endfunction

    // Bus handshakes, register writes and read answers
    always_comb begin
        logic [32:0] rd;
        logic [32:0] wr_hit;
        logic [15:0] wmask;
        pcs_pm_t req_state;
        rd = read_word(s_axi_araddr);
        wr_hit = read_word(aw_addr);
        wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
        req_state = pcs_pm_t'(w_data[1:0]);
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_dev_ctrl = dev_ctrl;
        next_pm_state = pm_state;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Commit only when both halves are here and the last answer has gone
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit[32] ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
            if (aw_addr == `PCS_OFF_DEV_CTRL) begin
                next_dev_ctrl = (dev_ctrl & ~wmask) | (w_data[15:0] & wmask);
                // Extended tag enable cannot stick without the capability
                next_dev_ctrl[8] = next_dev_ctrl[8] & CFG.ext_tag;
            end
            // Unsupported D-states are refused; leaving D3hot keeps dev_ctrl
            if (aw_addr == `PCS_OFF_PM_CTRL && w_strb[0] &&
                !(req_state == PCS_D1 && !CFG.d1) &&
                !(req_state == PCS_D2 && !CFG.d2)) begin
                next_pm_state = req_state;
            end
            // All other mapped words are fixed; the write is acknowledged only
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = rd[31:0];
            next_rresp = rd[32] ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // Bus and register flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PCS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `PCS_RESP_OKAY;
            s_axi_rdata <= 32'h0;
            dev_ctrl <= {7'h0, CFG.ext_tag_dflt & CFG.ext_tag, 8'h00};
            pm_state <= PCS_D0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            dev_ctrl <= next_dev_ctrl;
            pm_state <= next_pm_state;
        end
    end

    // Event gating toward the link side
    logic next_atomic_ur, next_atomic_fwd, next_intx_send, next_pme_send;
    logic next_speed_grant, next_speed_deny, next_deemph, next_ext_tag_active;

    always_comb begin
        logic auto_ok;
        logic reliab_ok;
        // Autonomous changes stop when disabled, reliability downshift stays
        auto_ok = !CFG.hw_auto_dis;
        reliab_ok = speed_req_reliab && (speed_req_to < link_speed_now);
        next_atomic_ur = atomic_req && CFG.ur_atomic;
        next_atomic_fwd = atomic_req && !CFG.ur_atomic;
        next_intx_send = intx_req && intx_ok;
        // Wake honoured only where advertised; D3cold never seen with clock up
        next_pme_send = power_wake_request && CFG.pme_from[pm_state];
        next_speed_grant = speed_req && (speed_req_to <= eff_tgt_speed) &&
                           (auto_ok || reliab_ok);
        next_speed_deny = speed_req && !next_speed_grant;
        next_deemph = (link_speed_now == `PCS_SPEED_5G) ? `PCS_DEEMPH_FIXED
                                                        : `PCS_DEEMPH_OFF;
        next_ext_tag_active = dev_ctrl[8];
    end

    // Event flops; every link-side output leaves from here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            atomic_ur <= 1'b0;
            atomic_fwd <= 1'b0;
            intx_send <= 1'b0;
            pme_send <= 1'b0;
            speed_grant <= 1'b0;
            speed_deny <= 1'b0;
            deemph_level <= `PCS_DEEMPH_OFF;
            ext_tag_active <= 1'b0;
            link_target_speed <= 4'h0;
            phantom_bits <= 2'h0;
            msix_active <= 1'b0;
        end else begin
            atomic_ur <= next_atomic_ur;
            atomic_fwd <= next_atomic_fwd;
            intx_send <= next_intx_send;
            pme_send <= next_pme_send;
            speed_grant <= next_speed_grant;
            speed_deny <= next_speed_deny;
            deemph_level <= next_deemph;
            ext_tag_active <= next_ext_tag_active;
            link_target_speed <= eff_tgt_speed;
            phantom_bits <= CFG.phantom;
            msix_active <= msix_ok;
        end
    end
endmodule // pcs_bank
`default_nettype wire

// ==== pcs_bank_monitor.sv ====
// Concurrent checks on the capability settings bank ports
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module pcs_bank_monitor
    import pcs_pkg::*;
#(
    parameter pcs_cfg_t CFG = PCS_CFG_DFLT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic atomic_req,
    input wire logic atomic_ur,
    input wire logic atomic_fwd,
    input wire logic intx_req,
    input wire logic intx_send,
    input wire logic power_wake_request,
    input wire logic pme_send,
    input wire logic speed_req,
    input wire logic [3:0] speed_req_to,
    input wire logic speed_req_reliab,
    input wire logic [3:0] link_speed_now,
    input wire logic speed_grant,
    input wire logic speed_deny,
    input wire logic [3:0] link_target_speed,
    input wire logic deemph_level,
    input wire logic [1:0] phantom_bits,
    input wire logic msix_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Event answers land exactly one cycle after their cause
    property p_atomic_route;
        atomic_req |=> atomic_ur == CFG.ur_atomic && atomic_fwd == !CFG.ur_atomic;
    endproperty
    a_atomic_route: assert property (p_atomic_route) else $error("atomic routing wrong");
    property p_intx_gate;
        intx_req |=> intx_send == (CFG.intx_en && CFG.intx_pin_a);
    endproperty
    a_intx_gate: assert property (p_intx_gate) else $error("legacy interrupt gating wrong");
    property p_intx_cause;
        intx_send |-> $past(intx_req);
    endproperty
    a_intx_cause: assert property (p_intx_cause) else $error("legacy interrupt unrequested");
    property p_speed_one;
        speed_req |=> speed_grant != speed_deny;
    endproperty
    a_speed_one: assert property (p_speed_one) else $error("speed answer not single");
    property p_speed_cap;
        speed_grant |-> $past(speed_req_to) <= link_target_speed;
    endproperty
    a_speed_cap: assert property (p_speed_cap) else $error("speed above target granted");
    property p_speed_hw;
        speed_grant && CFG.hw_auto_dis |-> $past(speed_req_reliab)
            && $past(speed_req_to) < $past(link_speed_now);
    endproperty
    a_speed_hw: assert property (p_speed_hw) else $error("autonomous speed change granted");
    // Registered outputs are only judged once a full cycle out of reset
    property p_deemph;
        $past(aresetn) |-> deemph_level == ($past(link_speed_now) == `PCS_SPEED_5G);
    endproperty
    a_deemph: assert property (p_deemph) else $error("de-emphasis level wrong");
    property p_pme_cause;
        pme_send |-> $past(power_wake_request);
    endproperty
    a_pme_cause: assert property (p_pme_cause) else $error("wake sent unrequested");
    property p_static;
        $past(aresetn) |-> phantom_bits == CFG.phantom
            && msix_active == (CFG.msix_en && |CFG.mem_bar_mask);
    endproperty
    a_static: assert property (p_static) else $error("static option outputs wrong");
    c_grant: cover property (speed_grant);
    c_deny: cover property (speed_deny);
    c_pme: cover property (pme_send);
endmodule // pcs_bank_monitor
bind pcs_bank pcs_bank_monitor #(.CFG(CFG)) mon_u (.*);
`default_nettype wire

// ==== pcs_link_model.sv ====
// Link partner model driving link-side events into the bank
`timescale 1ns/1ps
`default_nettype none
module pcs_link_model (
    input wire logic aclk,
    output logic atomic_req,
    output logic intx_req,
    output logic power_wake_request,
    output logic speed_req,
    output logic [3:0] speed_req_to,
    output logic speed_req_reliab,
    output logic [3:0] link_speed_now
);
    // Quiet at time zero, link trained at the lowest rate
    initial begin
        {speed_req, power_wake_request, intx_req, atomic_req} = 4'h0;
        speed_req_to = 4'h0;
        speed_req_reliab = 1'b0;
        link_speed_now = 4'h1;
    end
    // One-cycle pulse; speed fields turn to junk after it so nothing leans on them
    task automatic fire(input logic [3:0] k, input logic [3:0] to, input logic rel);
        @(posedge aclk);
        {speed_req, power_wake_request, intx_req, atomic_req} <= k;
        speed_req_to <= to;
        speed_req_reliab <= rel;
        @(posedge aclk);
        {speed_req, power_wake_request, intx_req, atomic_req} <= 4'h0;
        speed_req_to <= ~to;
        speed_req_reliab <= ~rel;
    endtask
    task automatic set_speed(input logic [3:0] s);
        @(posedge aclk);
        link_speed_now <= s;
    endtask
endmodule // pcs_link_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the capability settings bank
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module tb;
    import pcs_pkg::*;
    // Non-default options; every field shows at a read but at64, d2, finite_cpl, cpl_space and aspm_sup
    localparam pcs_cfg_t CFG = '{mps: 3'h1, phantom: 2'h2, ext_tag: 1'b1, ext_tag_dflt: 1'b1,
        ur_atomic: 1'b1, at32: 1'b1, cas128: 1'b1, bus_master_opt: 1'b1, sup_speed: 4'h2,
        max_width: 6'h4, aspm_sup: 2'h3, aspm_opt: 1'b1, dll_rpt: 1'b1, tgt_speed: 4'h1,
        hw_auto_dis: 1'b1, slot_clk: 1'b1, intx_en: 1'b1, intx_pin_a: 1'b1, msi_en: 1'b1,
        msi64: 1'b1, msi_mmc: 3'h3, msi_pvm: 1'b1, msix_en: 1'b1, msix_size: 11'h7,
        msix_bir: 3'h1, msix_off: 29'h100, pba_bir: 3'h2, pba_off: 29'h200,
        mem_bar_mask: 6'h07, bar64_mask: 6'h01, dsi: 1'b1, d1: 1'b1, pme_from: 5'h09,
        default: '0};
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic atomic_req, atomic_ur, atomic_fwd, intx_req, intx_send, power_wake_request;
    wire logic pme_send, speed_req, speed_req_reliab, speed_grant, speed_deny, deemph_level;
    wire logic ext_tag_active, msix_active;
    wire logic [3:0] speed_req_to, link_speed_now, link_target_speed;
    wire logic [1:0] phantom_bits;
    logic [31:0] exp_tab [16];
    int n_errors = 0;
    int comparisons = 0;
    pcs_bank #(.CFG(CFG)) dut_u (.*);
    pcs_link_model lp_u (.*);
    always #2.5 aclk = ~aclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One bus transfer; each valid held until its own ready edge, bounded wait
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic [1:0] r);
        int i;
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = !wr;
        q = '0;
        r = 2'h3;
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (!ta && (wr ? s_axi_awready : s_axi_arready)) begin
                ta = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (!tw && s_axi_wready) begin
                tw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (wr ? s_axi_bvalid : s_axi_rvalid) begin
                if (!wr) q = s_axi_rdata;
                r = wr ? s_axi_bresp : s_axi_rresp;
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (i == 40) begin
            n_errors++;
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] rexp);
        logic [31:0] q;
        logic [1:0] r;
        xfer(1'b1, a, d, s, q, r);
        chk(r, rexp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
        logic [31:0] q;
        logic [1:0] r;
        xfer(1'b0, a, 32'h0, 4'h0, q, r);
        chk(q, exp);
        chk(r, rexp);
    endtask
    // Pulse one event and gather all event answers a cycle later
    task automatic ev(input logic [3:0] k, input logic [3:0] to, input logic rel,
                      input logic [5:0] exp);
        lp_u.fire(k, to, rel);
        @(posedge aclk);
        chk({atomic_ur, atomic_fwd, intx_send, pme_send, speed_grant, speed_deny}, exp);
    endtask
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        exp_tab = '{32'h31, 32'h100, 32'h280, 32'h840,
            32'h100042, 32'h61, 32'h1000, 32'h101,
            32'h2f, 32'h807, 32'h800, 32'h1002,
            32'h4a20, 32'h8, 32'h0, 32'hd};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            rd(8'(k * 4), exp_tab[k], `PCS_RESP_OKAY);
        end
        chk({phantom_bits, msix_active, link_target_speed, ext_tag_active}, 32'ha3);
        $display("test reset_contents done");
        // Writes to read-only words must leave every value intact
        for (int k = 0; k < 16; k++) begin
            if (k != 1 && k != 13) wr(8'(k * 4), 32'hffff_ffff, 4'hf, `PCS_RESP_OKAY);
        end
        for (int k = 0; k < 16; k++) begin
            rd(8'(k * 4), exp_tab[k], `PCS_RESP_OKAY);
        end
        wr(8'h40, 32'h1, 4'hf, `PCS_RESP_SLVERR);
        rd(8'h40, 32'h0, `PCS_RESP_SLVERR);
        $display("test read_only done");
        wr(`PCS_OFF_DEV_CTRL, 32'h0, 4'h2, `PCS_RESP_OKAY);
        rd(`PCS_OFF_DEV_CTRL, 32'h0, `PCS_RESP_OKAY);
        chk(ext_tag_active, 32'h0);
        wr(`PCS_OFF_DEV_CTRL, 32'hffff_ffff, 4'h1, `PCS_RESP_OKAY);
        rd(`PCS_OFF_DEV_CTRL, 32'h00ff, `PCS_RESP_OKAY);
        wr(`PCS_OFF_DEV_CTRL, 32'hffff_ffff, 4'hf, `PCS_RESP_OKAY);
        rd(`PCS_OFF_DEV_CTRL, 32'hffff, `PCS_RESP_OKAY);
        chk(ext_tag_active, 32'h1);
        $display("test device_control done");
        // Wake honoured in D3hot, refused in D1; D2 unsupported is ignored
        wr(`PCS_OFF_PM_CTRL, 32'h3, 4'h1, `PCS_RESP_OKAY);
        ev(4'h4, 4'h0, 1'b0, 6'h04);
        wr(`PCS_OFF_PM_CTRL, 32'h0, 4'h1, `PCS_RESP_OKAY);
        rd(`PCS_OFF_DEV_CTRL, 32'hffff, `PCS_RESP_OKAY);
        wr(`PCS_OFF_PM_CTRL, 32'h2, 4'h1, `PCS_RESP_OKAY);
        rd(`PCS_OFF_PM_CTRL, 32'h8, `PCS_RESP_OKAY);
        wr(`PCS_OFF_PM_CTRL, 32'h1, 4'h1, `PCS_RESP_OKAY);
        rd(`PCS_OFF_PM_CTRL, 32'h9, `PCS_RESP_OKAY);
        ev(4'h4, 4'h0, 1'b0, 6'h00);
        $display("test power_states done");
        lp_u.set_speed(4'h2);
        ev(4'h1, 4'h0, 1'b0, 6'h20);
        ev(4'h2, 4'h0, 1'b0, 6'h08);
        ev(4'h8, 4'h1, 1'b1, 6'h02);
        ev(4'h8, 4'h1, 1'b0, 6'h01);
        ev(4'h8, 4'h2, 1'b1, 6'h01);
        chk(deemph_level, 32'h1);
        lp_u.set_speed(4'h1);
        repeat (2) @(posedge aclk);
        chk(deemph_level, 32'h0);
        $display("test link_events done");
        results();
    end
endmodule // tb
`default_nettype wire
